// >>> eeprom_protect_defines.vh
`ifndef EEPROM_PROTECT_DEFINES_VH
`define EEPROM_PROTECT_DEFINES_VH

// Register byte offsets
`define REG_STATUS      8'h00
`define REG_CMD         8'h04
`define REG_MEM_ADDR    8'h08
`define REG_RESULT      8'h0C
`define REG_SERIAL      8'h10

// Status byte fields (also the data layout of a status store command)
`define ST_LOCK         7
`define ST_SIZE_HI      3
`define ST_SIZE_LO      2
`define ST_LATCH        1
`define ST_BUSY         0
// Extra status fields seen only on the bus
`define ST_HW_LOCK      8
`define ST_HOLD         9
`define ST_SELECTED     10

// Command register bits
`define CMD_PERMIT      0
`define CMD_FORBID      1
`define CMD_STATUS      2
`define CMD_MEM         3

// Result register bits
`define RES_ST_OK       0
`define RES_ST_REFUSED  1
`define RES_MEM_OK      2
`define RES_MEM_REFUSED 3
`define RES_ABORTED     4

// Protect region lower bounds within the 10-bit array address
`define PROT_QUARTER    10'h300
`define PROT_HALF       10'h200

// Reset values of the nonvolatile bits
`define RST_LOCK        1'b0
`define RST_SIZE        2'b00

// Default length of an internal write cycle, in clock cycles
`define BUSY_CYCLES_DEF 20'h0_03E8

// Bus responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// >>> sync_bits.v
`timescale 1ns/100ps
module sync_bits #(
  parameter WIDTH = 6
) (
  // Clock and reset
  input  wire             clk,
  input  wire             resetn,
  // Asynchronous inputs and their synchronised copies
  input  wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  genvar i;
  // Two flip-flops per bit; the first stage feeds only the second
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage1;
      reg stage2;
      always @(posedge clk) begin
        if (!resetn) begin
          stage1 <= 1'b1;
          stage2 <= 1'b1;
        end else begin
          stage1 <= din[i];
          stage2 <= stage1;
        end
      end
      assign dout[i] = stage2;
    end
  endgenerate

endmodule // sync_bits

// >>> serial_eeprom_protect_hold.v
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "eeprom_protect_defines.vh"
module serial_eeprom_protect_hold #(
  parameter ADDR_W      = 8,
  parameter BUSY_W      = 20,
  parameter BUSY_CYCLES = `BUSY_CYCLES_DEF
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] awaddr,
  input  wire              awvalid,
  output wire              awready,
  // AXI4-Lite write data
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output wire              wready,
  // AXI4-Lite write response
  output reg  [1:0]        bresp,
  output reg               bvalid,
  input  wire              bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] araddr,
  input  wire              arvalid,
  output wire              arready,
  // AXI4-Lite read data
  output reg  [31:0]       rdata,
  output reg  [1:0]        rresp,
  output reg               rvalid,
  input  wire              rready,
  // Serial pins
  input  wire              cs_n,
  input  wire              sck,
  input  wire              si,
  input  wire              wp_n,
  input  wire              hold_n,
  input  wire              supply_low,
  output wire              so,
  output wire              so_oe,
  // Protection state
  output wire              hardware_lock_mode,
  output wire              write_busy
);

  // Synchronised pin levels
  wire [5:0] pins_s;
  wire       cs_n_s   = pins_s[5];
  wire       sck_s    = pins_s[4];
  wire       si_s     = pins_s[3];
  wire       wp_n_s   = pins_s[2];
  wire       hold_n_s = pins_s[1];
  wire       supply_s = pins_s[0];

  sync_bits #(
    .WIDTH (6)
  ) u_sync (
    .clk    (aclk),
    .resetn (aresetn),
    .din    ({cs_n, sck, si, wp_n, hold_n, supply_low}),
    .dout   (pins_s)
  );

  // Status and protection state
  reg              status_write_lock;
  reg              protect_size_hi;
  reg              protect_size_lo;
  reg              write_permit_latch;
  reg              write_busy_flag;
  reg [BUSY_W-1:0] busy_count;
  reg              pend_status;
  reg [2:0]        pend_value;
  reg [15:0]       mem_addr;
  reg [4:0]        result;

  // Serial transfer state
  reg              sck_d;
  reg              hold;
  reg [2:0]        bit_count;
  reg [7:0]        rx_shift;
  reg [7:0]        rx_byte;
  reg [7:0]        tx_shift;

  // Bus slave state
  reg              aw_got;
  reg              w_got;
  reg [ADDR_W-1:0] aw_q;
  reg [31:0]       w_q;
  reg [3:0]        ws_q;

  // Lock mode decode
  assign hardware_lock_mode = status_write_lock & ~wp_n_s;
  wire software_lock_mode = ~hardware_lock_mode;
  assign write_busy = write_busy_flag;

  // Protected region test on the low ten address bits
  function prot_hit;
    input [1:0] size;
    input [9:0] addr;
    begin
      case (size)
        2'b00:   prot_hit = 1'b0;
        2'b01:   prot_hit = (addr >= `PROT_QUARTER);
        2'b10:   prot_hit = (addr >= `PROT_HALF);
        default: prot_hit = 1'b1;
      endcase
    end
  endfunction

  // Write permission
  wire mem_hit = prot_hit({protect_size_hi, protect_size_lo}, mem_addr[9:0]);
  wire mem_ok  = write_permit_latch & ~write_busy_flag & ~mem_hit;
  wire stat_ok = write_permit_latch & ~write_busy_flag & software_lock_mode;

  wire [7:0] status_byte = {status_write_lock, 3'b000, protect_size_hi,
                            protect_size_lo, write_permit_latch, write_busy_flag};

  // Bus handshakes
  assign awready = ~aw_got & ~bvalid;
  assign wready  = ~w_got & ~bvalid;
  assign arready = ~rvalid;
  wire do_write = aw_got & w_got & ~bvalid;
  wire [ADDR_W-1:0] aw_word = {aw_q[ADDR_W-1:2], 2'b00};
  wire [ADDR_W-1:0] ar_word = {araddr[ADDR_W-1:2], 2'b00};
  wire wr_cmd  = do_write & (aw_word == `REG_CMD) & ws_q[0];
  wire wr_addr = do_write & (aw_word == `REG_MEM_ADDR);
  wire cmd_permit = wr_cmd & w_q[`CMD_PERMIT];
  wire cmd_forbid = wr_cmd & w_q[`CMD_FORBID];
  wire cmd_status = wr_cmd & w_q[`CMD_STATUS];
  wire cmd_mem    = wr_cmd & w_q[`CMD_MEM] & ~w_q[`CMD_STATUS];
  wire wr_mapped  = (aw_word == `REG_STATUS) | (aw_word == `REG_CMD) |
                    (aw_word == `REG_MEM_ADDR) | (aw_word == `REG_RESULT) |
                    (aw_word == `REG_SERIAL);

  // Write address and data capture, response generation
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_q   <= {ADDR_W{1'b0}};
      w_q    <= 32'h0000_0000;
      ws_q   <= 4'h0;
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_q   <= awaddr;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_q   <= wdata;
        ws_q  <= wstrb;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read data mux
  reg [31:0] next_rdata;
  reg        next_rerr;
  always @* begin
    next_rdata = 32'h0000_0000;
    next_rerr  = 1'b0;
    case (ar_word)
      `REG_STATUS: begin
        next_rdata[7:0]          = status_byte;
        next_rdata[`ST_HW_LOCK]  = hardware_lock_mode;
        next_rdata[`ST_HOLD]     = hold;
        next_rdata[`ST_SELECTED] = ~cs_n_s;
      end
      `REG_CMD:      next_rdata = 32'h0000_0000;
      `REG_MEM_ADDR: next_rdata[15:0] = mem_addr;
      `REG_RESULT:   next_rdata[4:0] = result;
      `REG_SERIAL:   next_rdata[10:0] = {bit_count, rx_byte};
      default:       next_rerr = 1'b1;
    endcase
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= next_rdata;
      rresp  <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Memory target address register
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_addr <= 16'h0000;
    end else if (wr_addr) begin
      if (ws_q[0]) mem_addr[7:0] <= w_q[7:0];
      if (ws_q[1]) mem_addr[15:8] <= w_q[15:8];
    end
  end

  // Permit latch, write cycle timer and status bits
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_write_lock  <= `RST_LOCK;
      {protect_size_hi, protect_size_lo} <= `RST_SIZE;
      write_permit_latch <= 1'b0;
      write_busy_flag    <= 1'b0;
      busy_count         <= {BUSY_W{1'b0}};
      pend_status        <= 1'b0;
      pend_value         <= 3'b000;
      result             <= 5'b00000;
    end else if (supply_s) begin
      // Low supply cancels the cycle; pending status never lands
      write_permit_latch  <= 1'b0;
      write_busy_flag     <= 1'b0;
      busy_count          <= {BUSY_W{1'b0}};
      pend_status         <= 1'b0;
      result[`RES_ABORTED] <= result[`RES_ABORTED] | write_busy_flag;
    end else if (write_busy_flag) begin
      // Count the internal write, then apply status and drop the latch
      busy_count <= busy_count - 1'b1;
      if (busy_count == {{(BUSY_W-1){1'b0}}, 1'b1}) begin
        write_busy_flag    <= 1'b0;
        write_permit_latch <= 1'b0;
        pend_status        <= 1'b0;
        if (pend_status) begin
          status_write_lock <= pend_value[2];
          protect_size_hi   <= pend_value[1];
          protect_size_lo   <= pend_value[0];
        end
      end
    end else begin
      if (cmd_permit && !cmd_forbid)
        write_permit_latch <= 1'b1;
      if (cmd_forbid)
        write_permit_latch <= 1'b0;
      if (cmd_status) begin
        result <= {1'b0, 2'b00, ~stat_ok, stat_ok};
        if (stat_ok) begin
          write_busy_flag <= 1'b1;
          busy_count      <= BUSY_CYCLES[BUSY_W-1:0];
          pend_status     <= 1'b1;
          pend_value      <= {w_q[`ST_LOCK], w_q[`ST_SIZE_HI], w_q[`ST_SIZE_LO]};
        end
      end else if (cmd_mem) begin
        result <= {1'b0, ~mem_ok, mem_ok, 2'b00};
        if (mem_ok) begin
          write_busy_flag <= 1'b1;
          busy_count      <= BUSY_CYCLES[BUSY_W-1:0];
          pend_status     <= 1'b0;
        end
      end
    end
  end

  // Serial clock edges, seen only through the synchroniser
  wire selected = ~cs_n_s;
  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;

  // Hold tracks the pause pin only while the serial clock is low
  always @(posedge aclk) begin
    if (!aresetn) begin
      sck_d <= 1'b0;
      hold  <= 1'b0;
    end else begin
      sck_d <= sck_s;
      if (!selected)
        hold <= 1'b0;
      else if (!sck_s)
        hold <= ~hold_n_s;
    end
  end

  // Shift registers and bit counter, frozen during hold
  always @(posedge aclk) begin
    if (!aresetn) begin
      bit_count <= 3'b000;
      rx_shift  <= 8'h00;
      rx_byte   <= 8'h00;
      tx_shift  <= 8'h00;
    end else if (!selected) begin
      bit_count <= 3'b000;
      tx_shift  <= status_byte;
    end else if (!hold) begin
      if (sck_rise) begin
        rx_shift  <= {rx_shift[6:0], si_s};
        bit_count <= bit_count + 3'b001;
        if (bit_count == 3'b111)
          rx_byte <= {rx_shift[6:0], si_s};
      end
      if (sck_fall) begin
        if (bit_count == 3'b000)
          tx_shift <= status_byte;
        else
          tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  // Serial output enabled only while selected and not held
  assign so    = tx_shift[7];
  assign so_oe = selected & ~hold;

endmodule // serial_eeprom_protect_hold

// >>> eeprom_protect_monitor.sv
`timescale 1ns/100ps
module eeprom_protect_monitor (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus handshakes
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire        bvalid,
  input wire        arvalid,
  input wire        arready,
  input wire        rvalid,
  // Pins and protection state
  input wire        cs_n,
  input wire        wp_n,
  input wire        supply_low,
  input wire        so_oe,
  input wire        hardware_lock_mode,
  input wire        write_busy
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answers and refusals
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write not answered in time");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered in time");
  a_write_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_read_refuse: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  // Pin driven output, lock state and write busy follow their causes
  a_oe_select: assert property (so_oe |-> !($past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3)))
    else $error("serial output driven while deselected");
  a_lock_pin: assert property (hardware_lock_mode |-> !($past(wp_n) && $past(wp_n, 2) && $past(wp_n, 3)))
    else $error("hardware lock with guard pin high");
  a_supply_abort: assert property (supply_low [*3] |=> !write_busy)
    else $error("write survived low supply");
  a_busy_cmd: assert property ($rose(write_busy) |-> $rose(bvalid))
    else $error("write cycle started without a command");
  // Main scenarios reached
  c_lock: cover property (hardware_lock_mode);
  c_busy: cover property ($rose(write_busy));
  c_serial: cover property (so_oe && !cs_n);
endmodule // eeprom_protect_monitor

bind serial_eeprom_protect_hold eeprom_protect_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .cs_n(cs_n), .wp_n(wp_n), .supply_low(supply_low), .so_oe(so_oe),
  .hardware_lock_mode(hardware_lock_mode), .write_busy(write_busy));

// >>> spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
  // Clock
  input  wire aclk,
  // Serial pins
  output reg  cs_n = 1'b1,
  output reg  sck = 1'b0,
  output wire si,
  output reg  hold_n = 1'b1,
  input  wire so
);
  reg       si_bit = 1'b0;
  reg       si_drv = 1'b0;
  reg       noise = 1'b0;
  reg [7:0] rx = 8'h00;
  // Undriven data line flips each cycle so stale data never passes
  always @(posedge aclk) noise <= ~noise;
  assign si = si_drv ? si_bit : noise;
  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Select stays low through any pause unless a test ends it
  task automatic sel(input v);
    @(posedge aclk);
    cs_n <= v;
    w(4);
  endtask
  task automatic pause(input v);
    @(posedge aclk);
    hold_n <= v;
  endtask
  // One 40 ns level of the 120 ns link clock; it rests low between frames
  task automatic level(input v);
    @(posedge aclk);
    sck <= v;
    w(3);
  endtask
  // Shift n bits out, most significant first, capturing so before each rise
  task automatic bits(input [7:0] tx, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge aclk);
      si_bit <= tx[i];
      si_drv <= 1'b1;
      w(3);
      rx <= {rx[6:0], so};
      level(1'b1);
      level(1'b0);
    end
    @(posedge aclk);
    si_drv <= 1'b0;
  endtask
endmodule // spi_host_model

// >>> test_serial_eeprom_protect_hold.sv
`timescale 1ns/100ps
`include "eeprom_protect_defines.vh"
module test_serial_eeprom_protect_hold;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  awaddr = 8'h00;
  reg  [31:0] wdata = 32'h0000_0000;
  reg         awvalid = 1'b0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg  [7:0]  araddr = 8'h00;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  reg         wp_n = 1'b1;
  reg         supply_low = 1'b0;
  wire        awready, wready, bvalid, arready, rvalid, so, so_oe, hw_lock, busy;
  wire        cs_n, sck, si, hold_n;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  reg  [3:0]  wstrb = 4'hF;
  // Released serial output shows the inverse, so a sample taken while floating fails
  wire        so_line = so_oe ? so : ~so;
  reg  [31:0] d;
  reg  [1:0]  r;
  reg  [15:0] ma [3] = '{16'hFEFF, 16'h0300, 16'hFF00};
  reg  [4:0]  mr [3] = '{5'h04, 5'h08, 5'h08};
  int         n_mismatch = 0;
  int         n_compared = 0;
  int         cyc = 0;

  serial_eeprom_protect_hold #(.BUSY_CYCLES(20'h0_000C)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .cs_n(cs_n), .sck(sck),
    .si(si), .wp_n(wp_n), .hold_n(hold_n), .supply_low(supply_low), .so(so), .so_oe(so_oe),
    .hardware_lock_mode(hw_lock), .write_busy(busy));
  spi_host_model host (.aclk(aclk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .so(so_line));

  // Clock and hang guard
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input [31:0] seen, input [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Bus write: both items offered together, each released once taken
  task automatic wr(input [7:0] a, input [31:0] v);
    reg ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      {ta, tw, tb} = {awready, wready, bvalid};
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask
  task automatic rd(input [7:0] a);
    reg ta, tv;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      {ta, tv} = {arready, rvalid};
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tv);
    rready <= 1'b0;
  endtask
  task automatic st(input [31:0] m, input [31:0] e);
    rd(`REG_STATUS);
    chk(d & m, e);
  endtask
  task automatic cmd(input [31:0] v, input [4:0] e);
    wr(`REG_CMD, v);
    rd(`REG_RESULT);
    chk(d[4:0], e);
  endtask
  task automatic results;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Test sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    st(32'h0000_07FF, 32'h0000_0000);
    wr(8'hE6, 32'h0000_0001);
    chk(r, `RESP_SLVERR);
    rd(8'hE6);
    chk(d, 32'h0000_0000);
    chk(r, `RESP_SLVERR);
    cmd(32'h0000_008C, 5'h02);
    st(32'h0000_008F, 32'h0000_0000);
    wstrb <= 4'hE;
    wr(`REG_CMD, 32'h0000_0001);
    wstrb <= 4'hF;
    st(32'h0000_0002, 32'h0000_0000);
    $display("Test reset and refusals done");
    wp_n <= 1'b0;
    wr(`REG_CMD, 32'h0000_0001);
    st(32'h0000_0002, 32'h0000_0002);
    cmd(32'h0000_0004, 5'h01);
    chk(busy, 1'b1);
    idle(16);
    st(32'h0000_008F, 32'h0000_0004);
    foreach (ma[i]) begin
      wr(`REG_MEM_ADDR, {16'h0000, ma[i]});
      wr(`REG_CMD, 32'h0000_0001);
      cmd(32'h0000_0008, mr[i]);
      idle(16);
    end
    rd(`REG_MEM_ADDR);
    chk(d[15:0], 16'hFF00);
    wstrb <= 4'h2;
    wr(8'h0B, 32'h0000_1234);
    wstrb <= 4'hF;
    rd(8'h0A);
    chk(d[15:0], 16'h1200);
    $display("Test quarter region done");
    wr(`REG_CMD, 32'h0000_0001);
    cmd(32'h0000_008C, 5'h01);
    idle(16);
    chk(hw_lock, 1'b1);
    wr(`REG_CMD, 32'h0000_0001);
    cmd(32'h0000_0004, 5'h02);
    st(32'h0000_008C, 32'h0000_008C);
    wr(`REG_MEM_ADDR, 32'h0000_0000);
    wr(`REG_CMD, 32'h0000_0001);
    cmd(32'h0000_0008, 5'h08);
    wp_n <= 1'b1;
    idle(4);
    chk(hw_lock, 1'b0);
    wr(`REG_CMD, 32'h0000_0001);
    cmd(32'h0000_0084, 5'h01);
    idle(16);
    wp_n <= 1'b0;
    idle(4);
    st(32'h0000_0100, 32'h0000_0100);
    wp_n <= 1'b1;
    wr(`REG_CMD, 32'h0000_0001);
    cmd(32'h0000_0004, 5'h01);
    idle(16);
    $display("Test lock modes done");
    wr(`REG_CMD, 32'h0000_0001);
    wr(`REG_CMD, 32'h0000_000C);
    supply_low <= 1'b1;
    idle(4);
    supply_low <= 1'b0;
    idle(4);
    rd(`REG_RESULT);
    chk(d[4], 1'b1);
    st(32'h0000_008F, 32'h0000_0004);
    cmd(32'h0000_000C, 5'h02);
    wr(`REG_CMD, 32'h0000_0003);
    st(32'h0000_0002, 32'h0000_0000);
    $display("Test low supply done");
    host.sel(1'b0);
    host.bits(8'hA5, 8);
    chk(host.rx, 8'h04);
    rd(`REG_SERIAL);
    chk(d[10:0], 11'h0A5);
    host.bits(8'h3C, 4);
    host.pause(1'b0);
    host.w(4);
    chk(so_oe, 1'b0);
    st(32'h0000_0200, 32'h0000_0200);
    host.level(1'b1);
    host.level(1'b0);
    host.pause(1'b1);
    host.w(4);
    host.bits(8'hC0, 4);
    rd(`REG_SERIAL);
    chk(d[10:0], 11'h03C);
    host.level(1'b1);
    host.pause(1'b0);
    host.w(6);
    st(32'h0000_0200, 32'h0000_0000);
    host.level(1'b0);
    st(32'h0000_0200, 32'h0000_0200);
    host.sel(1'b1);
    st(32'h0000_0400, 32'h0000_0000);
    rd(`REG_SERIAL);
    chk(d[10:8], 3'h0);
    host.pause(1'b1);
    $display("Test serial and pause done");
    results();
  end
endmodule // test_serial_eeprom_protect_hold
